// >>> core/pcra_pkg.sv
package pcra_pkg;
   // register offsets, 16-bit registers at their byte offsets
   localparam logic [15:0] OFS_CTRL = 16'h0500;
   localparam logic [15:0] OFS_PHASE = 16'h0502;
   localparam logic [15:0] OFS_NS_HI = 16'h0504;
   localparam logic [15:0] OFS_NS_LO = 16'h0506;
   localparam logic [15:0] OFS_SEC_HI = 16'h0508;
   localparam logic [15:0] OFS_SEC_LO = 16'h050A;
   localparam logic [15:0] OFS_RATE_HI = 16'h050C;
   localparam logic [15:0] OFS_RATE_LO = 16'h050E;
   localparam logic [15:0] OFS_DUR_HI = 16'h0510;
   localparam logic [15:0] OFS_DUR_LO = 16'h0512;
   // control register bits
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int CTRL_CONT_ADJ_BIT = 2;
   localparam int CTRL_LOAD_BIT = 3;
   localparam int CTRL_READ_BIT = 4;
   // rate high word fields
   localparam int RATE_DIR_BIT = 15;
   localparam int TEMP_ADJ_BIT = 14;
   localparam int RATE_HI_MSB = 13;
   // widths and reset values
   localparam int REG_W = 16;
   localparam int PHASE_W = 3;
   localparam int RATE_STEP_W = 30;
   localparam int DUR_COUNT_W = 32;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // timing: reference clock and time-of-day step clock
   localparam int unsigned REF_CLK_HZ = 100_000_000;
   localparam int unsigned RTC_CLK_HZ = 25_000_000;
   localparam int unsigned NS_PER_SEC = 1_000_000_000;
   localparam int unsigned TICK_DIV = REF_CLK_HZ / RTC_CLK_HZ;
   localparam int unsigned NS_PER_TICK = NS_PER_SEC / RTC_CLK_HZ;
endpackage : pcra_pkg

// >>> core/pcra_rate_adjust.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module pcra_rate_adjust
   import pcra_pkg::*;
#(
   parameter int RATE_W = RATE_STEP_W,
   parameter int DUR_W = DUR_COUNT_W,
   parameter int DIV = TICK_DIV
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic [REG_W-1:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [REG_W-1:0] o_rd_data,
   // running clock and status
   output logic [31:0] o_rtc_seconds,
   output logic [31:0] o_rtc_nanosec,
   output logic [RATE_W-1:0] o_rtc_frac,
   output logic o_rtc_tick,
   output logic o_temp_active
);

   localparam int TOD_W = 64;
   localparam logic [TOD_W-1:0] SEC_FX =
      TOD_W'(NS_PER_SEC) << RATE_W;
   localparam logic [TOD_W-1:0] TICK_FX =
      TOD_W'(NS_PER_TICK) << RATE_W;
   localparam int DIV_W = $clog2(DIV + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
   localparam logic [DUR_W-1:0] DUR_ONE = DUR_W'(1);

   // software-visible words
   logic [PHASE_W-1:0] phase;
   logic [REG_W-1:0] ns_hi;
   logic [REG_W-1:0] ns_lo;
   logic [REG_W-1:0] sec_hi;
   logic [REG_W-1:0] sec_lo;
   logic rate_dir;
   logic temp_en;
   logic [RATE_HI_MSB:0] rate_hi;
   logic [REG_W-1:0] rate_lo;
   logic [REG_W-1:0] dur_hi;
   logic [REG_W-1:0] dur_lo;
   logic clk_en;
   logic cont_adj;

   // running time and sequencing
   logic [31:0] run_sec;
   logic [31:0] run_ns;
   logic [RATE_W-1:0] run_frac;
   logic [DIV_W-1:0] div_cnt;
   logic [DUR_W-1:0] dur_cnt;
   logic tick;

   // address decode
   wire sel_ctrl = (i_addr == OFS_CTRL);
   wire sel_phase = (i_addr == OFS_PHASE);
   wire sel_ns_hi = (i_addr == OFS_NS_HI);
   wire sel_ns_lo = (i_addr == OFS_NS_LO);
   wire sel_sec_hi = (i_addr == OFS_SEC_HI);
   wire sel_sec_lo = (i_addr == OFS_SEC_LO);
   wire sel_rate_hi = (i_addr == OFS_RATE_HI);
   wire sel_rate_lo = (i_addr == OFS_RATE_LO);
   wire sel_dur_hi = (i_addr == OFS_DUR_HI);
   wire sel_dur_lo = (i_addr == OFS_DUR_LO);

   wire wr_ctrl = i_wr && sel_ctrl;
   wire wr_rate_hi = i_wr && sel_rate_hi;

   // self-clearing commands exist only as the write pulse
   wire cmd_reset = wr_ctrl && i_wr_data[CTRL_RESET_BIT];
   wire cmd_load = wr_ctrl && i_wr_data[CTRL_LOAD_BIT];
   wire cmd_read = wr_ctrl && i_wr_data[CTRL_READ_BIT];

   // temporary mode start and stop from software
   wire temp_start = wr_rate_hi && i_wr_data[TEMP_ADJ_BIT];
   wire temp_stop = wr_rate_hi && !i_wr_data[TEMP_ADJ_BIT];

   wire [DUR_W-1:0] dur_value = DUR_W'({dur_hi, dur_lo});
   wire [RATE_W-1:0] rate_step = RATE_W'({rate_hi, rate_lo});

   // the step is applied on the tick while either mode runs
   wire temp_expire = temp_en && tick && (dur_cnt <= DUR_ONE);
   wire adjusting = cont_adj || temp_en;

   wire [TOD_W-1:0] tod_now = TOD_W'({run_ns, run_frac});
   wire [TOD_W-1:0] base_step = clk_en ? TICK_FX : '0;
   wire [TOD_W-1:0] adj_step =
      adjusting ? TOD_W'(rate_step) : '0;
   // one direction bit serves both modes
   wire [TOD_W-1:0] tod_sum = rate_dir ?
      tod_now + base_step + adj_step :
      tod_now + base_step - adj_step;
   // a loaded value past one second walks back one second per tick
   wire tod_under = tod_sum[TOD_W-1];
   wire tod_over = !tod_under && (tod_sum >= SEC_FX);
   wire [TOD_W-1:0] tod_next = tod_under ? tod_sum + SEC_FX :
      tod_over ? tod_sum - SEC_FX : tod_sum;
   wire [31:0] sec_next = tod_under ? run_sec - 32'h0000_0001 :
      tod_over ? run_sec + 32'h0000_0001 : run_sec;

   // read mux, registered below
   logic [REG_W-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      if (sel_ctrl)
      begin
         rd_mux[CTRL_ENABLE_BIT] = clk_en;
         rd_mux[CTRL_CONT_ADJ_BIT] = cont_adj;
      end
      else if (sel_phase)
         rd_mux = REG_W'(phase);
      else if (sel_ns_hi)
         rd_mux = ns_hi;
      else if (sel_ns_lo)
         rd_mux = ns_lo;
      else if (sel_sec_hi)
         rd_mux = sec_hi;
      else if (sel_sec_lo)
         rd_mux = sec_lo;
      else if (sel_rate_hi)
      begin
         rd_mux[RATE_DIR_BIT] = rate_dir;
         rd_mux[TEMP_ADJ_BIT] = temp_en;
         rd_mux[RATE_HI_MSB:0] = rate_hi;
      end
      else if (sel_rate_lo)
         rd_mux = rate_lo;
      else if (sel_dur_hi)
         rd_mux = dur_hi;
      else if (sel_dur_lo)
         rd_mux = dur_lo;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rd_data <= REG_RESET;
      else if (i_rd)
         o_rd_data <= rd_mux;
      else
         o_rd_data <= REG_RESET;
   end

   // control bits
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         clk_en <= 1'b0;
         cont_adj <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         clk_en <= i_wr_data[CTRL_ENABLE_BIT];
         cont_adj <= i_wr_data[CTRL_CONT_ADJ_BIT];
      end
   end

   // rate words and duration words
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rate_dir <= 1'b0;
         rate_hi <= '0;
         rate_lo <= REG_RESET;
         dur_hi <= REG_RESET;
         dur_lo <= REG_RESET;
      end
      else
      begin
         if (wr_rate_hi)
         begin
            rate_dir <= i_wr_data[RATE_DIR_BIT];
            rate_hi <= i_wr_data[RATE_HI_MSB:0];
         end
         if (i_wr && sel_rate_lo)
            rate_lo <= i_wr_data;
         if (i_wr && sel_dur_hi)
            dur_hi <= i_wr_data;
         if (i_wr && sel_dur_lo)
            dur_lo <= i_wr_data;
      end
   end

   // temporary adjustment; a software start beats the expiry clear
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         temp_en <= 1'b0;
         dur_cnt <= '0;
      end
      else if (temp_start)
      begin
         // a zero duration never starts
         temp_en <= (dur_value != '0);
         dur_cnt <= dur_value;
      end
      else if (temp_stop)
         temp_en <= 1'b0;
      else if (temp_expire)
      begin
         temp_en <= 1'b0;
         dur_cnt <= '0;
      end
      else if (temp_en && tick)
         dur_cnt <= dur_cnt - DUR_ONE;
   end

   // 25MHz step enable from the reference clock
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         div_cnt <= '0;
      else if (div_cnt == DIV_LAST)
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + DIV_W'(1);
   end
   assign tick = (div_cnt == DIV_LAST);

   // running clock: reset, then load, then stepping
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         run_sec <= '0;
         run_ns <= '0;
         run_frac <= '0;
      end
      else if (cmd_reset)
      begin
         run_sec <= '0;
         run_ns <= '0;
         run_frac <= '0;
      end
      else if (cmd_load)
      begin
         run_sec <= {sec_hi, sec_lo};
         run_ns <= {ns_hi, ns_lo};
         run_frac <= '0;
      end
      else if (tick)
      begin
         run_sec <= sec_next;
         run_ns <= tod_next[RATE_W +: 32];
         run_frac <= tod_next[RATE_W-1:0];
      end
   end

   // time words; a read command overrides a same-cycle write
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase <= '0;
         ns_hi <= REG_RESET;
         ns_lo <= REG_RESET;
         sec_hi <= REG_RESET;
         sec_lo <= REG_RESET;
      end
      else if (cmd_read)
      begin
         phase <= '0;
         ns_hi <= run_ns[31:16];
         ns_lo <= run_ns[15:0];
         sec_hi <= run_sec[31:16];
         sec_lo <= run_sec[15:0];
      end
      else if (i_wr)
      begin
         if (sel_phase)
            phase <= i_wr_data[PHASE_W-1:0];
         if (sel_ns_hi)
            ns_hi <= i_wr_data;
         if (sel_ns_lo)
            ns_lo <= i_wr_data;
         if (sel_sec_hi)
            sec_hi <= i_wr_data;
         if (sel_sec_lo)
            sec_lo <= i_wr_data;
      end
   end

   assign o_rtc_seconds = run_sec;
   assign o_rtc_nanosec = run_ns;
   assign o_rtc_frac = run_frac;
   assign o_rtc_tick = tick;
   assign o_temp_active = temp_en;

endmodule : pcra_rate_adjust

// >>> verification/pcra_rate_adjust_checker.sv
`timescale 1ns/100ps
module pcra_rate_adjust_checker
   import pcra_pkg::*;
#(
   parameter int RATE_W = RATE_STEP_W
)
(
   // clock, reset and register port
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_addr,
   input wire logic [REG_W-1:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [REG_W-1:0] o_rd_data,
   // running clock and status
   input wire logic [31:0] o_rtc_seconds,
   input wire logic [31:0] o_rtc_nanosec,
   input wire logic [RATE_W-1:0] o_rtc_frac,
   input wire logic o_rtc_tick,
   input wire logic o_temp_active
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_gap;
      !o_rtc_tick [*3];
   endsequence
   property p_tick_period;
      o_rtc_tick |=> s_gap ##1 o_rtc_tick;
   endproperty
   property p_rd_quiet;
      !i_rd |=> o_rd_data == 16'h0000;
   endproperty
   property p_unmapped;
      i_rd && i_addr == 16'h0514 |=> o_rd_data == 16'h0000;
   endproperty
   property p_stop;
      i_wr && i_addr == OFS_RATE_HI && !i_wr_data[TEMP_ADJ_BIT]
         |=> !o_temp_active;
   endproperty
   property p_start;
      $rose(o_temp_active) |-> $past(i_wr) && $past(i_addr) == OFS_RATE_HI
         && $past(i_wr_data[TEMP_ADJ_BIT]);
   endproperty
   property p_end;
      $fell(o_temp_active) |-> $past(o_rtc_tick) || $past(i_wr);
   endproperty
   // time only moves on a tick edge or after a register write
   property p_frac_idle;
      !o_rtc_tick && !i_wr && !$past(i_wr) |=> $stable(o_rtc_frac);
   endproperty
   property p_ns_range;
      o_rtc_nanosec < NS_PER_SEC;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("tick spacing off");
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("read data outside read slot");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_stop: assert property (p_stop)
      else $error("temporary mode not stopped");
   a_start: assert property (p_start)
      else $error("temporary mode rose without start write");
   a_end: assert property (p_end)
      else $error("temporary mode fell off tick");
   a_frac_idle: assert property (p_frac_idle)
      else $error("fraction moved between ticks");
   a_ns_range: assert property (p_ns_range)
      else $error("nanoseconds out of range");
endmodule : pcra_rate_adjust_checker

bind pcra_rate_adjust pcra_rate_adjust_checker #(.RATE_W(RATE_W)) u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
   .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
   .o_rtc_seconds(o_rtc_seconds), .o_rtc_nanosec(o_rtc_nanosec),
   .o_rtc_frac(o_rtc_frac), .o_rtc_tick(o_rtc_tick),
   .o_temp_active(o_temp_active));

// >>> verification/pcra_rate_adjust_test.sv
`timescale 1ns/100ps
module pcra_rate_adjust_test
   import pcra_pkg::*;
;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [15:0] i_wr_data = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rd_data;
   logic [31:0] o_rtc_seconds;
   logic [31:0] o_rtc_nanosec;
   logic [29:0] o_rtc_frac;
   logic o_rtc_tick;
   logic o_temp_active;
   int fails = 0;
   int comparisons = 0;
   pcra_rate_adjust u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
      .o_rd_data(o_rd_data), .o_rtc_seconds(o_rtc_seconds),
      .o_rtc_nanosec(o_rtc_nanosec), .o_rtc_frac(o_rtc_frac),
      .o_rtc_tick(o_rtc_tick), .o_temp_active(o_temp_active));
   initial
   begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("wrong value %s exp %h got %h", n, e, g);
         fails++;
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      chk("read data", {16'h0000, e}, {16'h0000, o_rd_data});
   endtask : rd
   // fraction change across the next tick edge
   task step(output logic [29:0] d);
      logic [29:0] f0;
      int n;
      n = 0;
      do
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      while (o_rtc_tick !== 1'b1 && n < 10);
      if (n >= 10)
      begin
         fails++;
         close_out();
      end
      else
      begin
         f0 = o_rtc_frac;
         @(posedge i_ref_clk);
         #1;
         d = o_rtc_frac - f0;
      end
   endtask : step
   task t_regs;
      logic [15:0] a;
      for (a = OFS_SEC_HI; a <= OFS_DUR_LO; a += 16'h0002)
         rd(a, 16'h0000);
      for (a = OFS_SEC_HI; a <= OFS_DUR_LO; a += 16'h0002)
         wr(a, a ^ 16'hBEEF);
      for (a = OFS_SEC_HI; a <= OFS_DUR_LO; a += 16'h0002)
         rd(a, a ^ 16'hBEEF);
      wr(16'h0514, 16'hFFFF);
      rd(16'h0514, 16'h0000);
      $display("register test done");
   endtask : t_regs
   task t_load;
      wr(OFS_SEC_HI, 16'h1234);
      wr(OFS_SEC_LO, 16'h5678);
      wr(OFS_NS_HI, 16'h0000);
      wr(OFS_NS_LO, 16'h0000);
      wr(OFS_CTRL, 16'h0008);
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk("seconds", 32'h1234_5678, o_rtc_seconds);
      wr(OFS_SEC_HI, 16'h0000);
      wr(OFS_SEC_LO, 16'h0000);
      wr(OFS_CTRL, 16'h0010);
      rd(OFS_SEC_HI, 16'h1234);
      rd(OFS_SEC_LO, 16'h5678);
      $display("load test done");
   endtask : t_load
   task t_cont;
      logic [29:0] d;
      wr(OFS_RATE_LO, 16'h0100);
      wr(OFS_RATE_HI, 16'h8000);
      wr(OFS_CTRL, 16'h0004);
      step(d);
      chk("add step", 32'h0000_0100, {2'b00, d});
      wr(OFS_RATE_HI, 16'h0000);
      step(d);
      chk("sub step", 32'h3FFF_FF00, {2'b00, d});
      wr(OFS_CTRL, 16'h0000);
      $display("continuous test done");
   endtask : t_cont
   task t_temp;
      logic [29:0] f0;
      int n;
      int k;
      wr(OFS_DUR_HI, 16'h0000);
      wr(OFS_DUR_LO, 16'h0003);
      #1;
      f0 = o_rtc_frac;
      wr(OFS_RATE_HI, 16'hC000);
      n = 0;
      k = 0;
      #1;
      // count from the start edge so a tick right after it is not missed
      while (o_temp_active === 1'b1 && k < 40)
      begin
         if (o_rtc_tick === 1'b1)
            n++;
         @(posedge i_ref_clk);
         #1;
         k++;
      end
      if (k >= 40)
      begin
         fails++;
         close_out();
      end
      else
      begin
         chk("temp ticks", 32'd3, n);
         chk("temp frac", 32'h0000_0300, {2'b00, o_rtc_frac - f0});
         rd(OFS_RATE_HI, 16'h8000);
         wr(OFS_DUR_LO, 16'h0064);
         wr(OFS_RATE_HI, 16'hC000);
         #1;
         chk("temp on", 32'd1, {31'd0, o_temp_active});
         wr(OFS_RATE_HI, 16'h8000);
         #1;
         chk("temp off", 32'd0, {31'd0, o_temp_active});
         $display("temporary test done");
      end
   endtask : t_temp
   task t_run;
      logic [29:0] d;
      logic [31:0] n0;
      // clear first so the nominal advance cannot cross a second
      wr(OFS_CTRL, 16'h0001);
      #1;
      chk("cleared seconds", 32'h0000_0000, o_rtc_seconds);
      chk("cleared nanoseconds", 32'h0000_0000, o_rtc_nanosec);
      wr(OFS_CTRL, 16'h0002);
      rd(OFS_CTRL, 16'h0002);
      step(d);
      chk("idle frac", 32'h0000_0000, {2'b00, d});
      n0 = o_rtc_nanosec;
      repeat (TICK_DIV) @(posedge i_ref_clk);
      #1;
      chk("nanoseconds", n0 + NS_PER_TICK, o_rtc_nanosec);
      // mid-run reset brings the words back to zero
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rd(OFS_SEC_HI, 16'h0000);
      rd(OFS_RATE_HI, 16'h0000);
      #1;
      chk("reset seconds", 32'h0000_0000, o_rtc_seconds);
      $display("run test done");
   endtask : t_run
   initial
   begin
      repeat (4) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_load();
      t_cont();
      t_temp();
      t_run();
      close_out();
   end
endmodule : pcra_rate_adjust_test
